// ### src/fpsr_defs.svh
// Register map, field layout, reset values and timing constants
//
// Notes on behaviour
// - A pulse mask bit of 0 fires that LED pulse; 1 suppresses it.
// - Slot B pulse mask is bits 15:12; bit 12 is the first pulse.
// - Slot A pulse mask is bits 11:8; bit 8 is the first pulse.
// - Slot A float enable: 0 disables, 3 enables; 1 and 2 reserved.
// - Slot A five-bit precondition time, reset 0x08, delays first float interval.
// - Status upper byte reports bytes available in the sample FIFO.
// - Threshold counts two-byte words; the status count is in bytes.
// - Writing 1 to status bit 15 empties the FIFO; count reads zero.
// - Status bit 5 sets on slot A sample; write 1 clears, 0 keeps.
// - Status bit 6 sets on slot B sample; write 1 clears, 0 keeps.
// - Reserved status bits 7 and 4:0 clear on written ones.
// - Mask bit 8, reset 1, enables the FIFO threshold interrupt when 0.
// - Slot B float enable: 0 disables, 3 enables; 1 and 2 reserved.
// - Mask bits 6 and 5, reset 1, suppress slot B and A interrupts.
`ifndef FPSR_DEFS_SVH
`define FPSR_DEFS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define FPSR_ADDR_STATUS 8'h00
`define FPSR_ADDR_MASK 8'h01
`define FPSR_ADDR_FLOAT_B 8'h59
`define FPSR_ADDR_PULSE 8'h5a
`define FPSR_ADDR_FLOAT_A 8'h5e

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FPSR_RST_MASK 16'h01ff
`define FPSR_RST_PULSE 16'h0010
`define FPSR_RST_FLOAT 16'h0808

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FPSR_FIFO_CLR_BIT 15
`define FPSR_CNT_MSB 15
`define FPSR_CNT_LSB 8
`define FPSR_FLAG_B_BIT 6
`define FPSR_FLAG_A_BIT 5
`define FPSR_FIFO_MASK_BIT 8
`define FPSR_PULSE_B_LSB 12
`define FPSR_PULSE_A_LSB 8
`define FPSR_FLT_EN_MSB 14
`define FPSR_FLT_EN_LSB 13
`define FPSR_PRECON_MSB 12
`define FPSR_PRECON_LSB 8
`define FPSR_FLT_EN_ON 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define FPSR_CLK_PERIOD_NS 25
`define FPSR_PRECON_UNIT_NS 2000
`define FPSR_PRECON_UNIT_CYC (`FPSR_PRECON_UNIT_NS / `FPSR_CLK_PERIOD_NS)

`endif

// ### src/fpsr_pkg.sv
// Shared types for the float, pulse and status register block
package fpsr_pkg;
  typedef enum logic {FPSR_TMR_IDLE, FPSR_TMR_PRECON} fpsr_tmr_t;
endpackage

// ### src/fpsr_regs.sv
// Float, pulse mask and system status registers with slot timing
`timescale 1ns/10ps
`default_nettype none
`include "fpsr_defs.svh"

module fpsr_regs #(
  parameter int CNT_W = 8,
  parameter int THR_W = 6,
  parameter int TMR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic slot_a_sample_evt,
  input wire logic slot_b_sample_evt,
  input wire logic fifo_word_push,
  input wire logic fifo_byte_pop,
  input wire logic [THR_W-1:0] fifo_thresh_words,
  input wire logic slot_a_pulse_req,
  input wire logic slot_b_pulse_req,
  input wire logic [1:0] pulse_index,
  output logic slot_a_led_fire,
  output logic slot_b_led_fire,
  input wire logic [1:0] slot_start,
  output logic [1:0] float_start,
  output logic fifo_clear,
  output logic irq
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  logic wr_status;
  logic wr_mask;
  logic wr_pulse;
  logic wr_flt_a;
  logic wr_flt_b;
  assign wr_status = reg_wr && hit(reg_addr, `FPSR_ADDR_STATUS);
  assign wr_mask = reg_wr && hit(reg_addr, `FPSR_ADDR_MASK);
  assign wr_pulse = reg_wr && hit(reg_addr, `FPSR_ADDR_PULSE);
  assign wr_flt_a = reg_wr && hit(reg_addr, `FPSR_ADDR_FLOAT_A);
  assign wr_flt_b = reg_wr && hit(reg_addr, `FPSR_ADDR_FLOAT_B);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [15:0] mask_reg, mask_next;
  logic [15:0] pulse_reg, pulse_next;
  logic [15:0] flt_a_reg, flt_a_next;
  logic [15:0] flt_b_reg, flt_b_next;

  always_comb begin
    mask_next = wr_mask ? reg_wdata : mask_reg;
    pulse_next = wr_pulse ? reg_wdata : pulse_reg;
    flt_a_next = wr_flt_a ? reg_wdata : flt_a_reg;
    flt_b_next = wr_flt_b ? reg_wdata : flt_b_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= `FPSR_RST_MASK;
      pulse_reg <= `FPSR_RST_PULSE;
      flt_a_reg <= `FPSR_RST_FLOAT;
      flt_b_reg <= `FPSR_RST_FLOAT;
    end else begin
      mask_reg <= mask_next;
      pulse_reg <= pulse_next;
      flt_a_reg <= flt_a_next;
      flt_b_reg <= flt_b_next;
    end
  end

  // ----------------------------------------
  // Status: FIFO count and sample flags
  // ----------------------------------------
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic flag_a_reg, flag_a_next;
  logic flag_b_reg, flag_b_next;
  logic clr_fifo;
  logic fifo_over;

  assign clr_fifo = wr_status && reg_wdata[`FPSR_FIFO_CLR_BIT];
  // Threshold in words, count in bytes
  assign fifo_over = cnt_reg > {{(CNT_W-THR_W-1){1'b0}}, fifo_thresh_words, 1'b0};

  always_comb begin
    cnt_next = cnt_reg;
    if (clr_fifo) begin
      cnt_next = '0;
    end else begin
      // Saturates rather than wraps if the source misbehaves
      if (fifo_word_push && cnt_reg < {CNT_W{1'b1}} - CNT_W'(1)) begin
        cnt_next = cnt_next + CNT_W'(2);
      end
      if (fifo_byte_pop && cnt_next != '0) begin
        cnt_next = cnt_next - CNT_W'(1);
      end
    end
    // Event in the clearing cycle wins
    flag_a_next = slot_a_sample_evt |
      (flag_a_reg & ~(wr_status & reg_wdata[`FPSR_FLAG_A_BIT]));
    flag_b_next = slot_b_sample_evt |
      (flag_b_reg & ~(wr_status & reg_wdata[`FPSR_FLAG_B_BIT]));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      flag_a_reg <= flag_a_next;
      flag_b_reg <= flag_b_next;
    end
  end

  // ----------------------------------------
  // Interrupt and FIFO clear strobe
  // ----------------------------------------
  logic irq_reg, irq_next;
  logic fclr_reg, fclr_next;

  always_comb begin
    irq_next = (flag_a_reg & ~mask_reg[`FPSR_FLAG_A_BIT]) |
               (flag_b_reg & ~mask_reg[`FPSR_FLAG_B_BIT]) |
               (fifo_over & ~mask_reg[`FPSR_FIFO_MASK_BIT]);
    fclr_next = clr_fifo;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
      fclr_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
      fclr_reg <= fclr_next;
    end
  end

  assign irq = irq_reg;
  assign fifo_clear = fclr_reg;

  // ----------------------------------------
  // Pulse firing
  // ----------------------------------------
  logic [3:0] skip_a;
  logic [3:0] skip_b;
  logic fire_a_reg, fire_a_next;
  logic fire_b_reg, fire_b_next;

  assign skip_a = pulse_reg[`FPSR_PULSE_A_LSB+3:`FPSR_PULSE_A_LSB];
  assign skip_b = pulse_reg[`FPSR_PULSE_B_LSB+3:`FPSR_PULSE_B_LSB];

  always_comb begin
    fire_a_next = slot_a_pulse_req & ~skip_a[pulse_index];
    fire_b_next = slot_b_pulse_req & ~skip_b[pulse_index];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fire_a_reg <= 1'b0;
      fire_b_reg <= 1'b0;
    end else begin
      fire_a_reg <= fire_a_next;
      fire_b_reg <= fire_b_next;
    end
  end

  assign slot_a_led_fire = fire_a_reg;
  assign slot_b_led_fire = fire_b_reg;

  // ----------------------------------------
  // Float preconditioning timers, index 0 slot A, 1 slot B
  // ----------------------------------------
  logic [15:0] flt_cfg [2];
  assign flt_cfg[0] = flt_a_reg;
  assign flt_cfg[1] = flt_b_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_slot
      fpsr_pkg::fpsr_tmr_t st_reg, st_next;
      logic [TMR_W-1:0] tmr_reg, tmr_next;
      logic fs_reg, fs_next;
      logic en;
      logic [4:0] precon;
      // Reserved codes 1 and 2 are treated as disabled
      assign en = flt_cfg[gi][`FPSR_FLT_EN_MSB:`FPSR_FLT_EN_LSB] == `FPSR_FLT_EN_ON;
      assign precon = flt_cfg[gi][`FPSR_PRECON_MSB:`FPSR_PRECON_LSB];

      always_comb begin
        st_next = st_reg;
        tmr_next = tmr_reg;
        fs_next = 1'b0;
        unique case (st_reg)
          fpsr_pkg::FPSR_TMR_IDLE: begin
            if (slot_start[gi] && en) begin
              st_next = fpsr_pkg::FPSR_TMR_PRECON;
              tmr_next = TMR_W'(precon * `FPSR_PRECON_UNIT_CYC);
            end
          end
          fpsr_pkg::FPSR_TMR_PRECON: begin
            if (!en) begin
              st_next = fpsr_pkg::FPSR_TMR_IDLE;
            end else if (tmr_reg == '0) begin
              fs_next = 1'b1;
              st_next = fpsr_pkg::FPSR_TMR_IDLE;
            end else begin
              tmr_next = tmr_reg - TMR_W'(1);
            end
          end
        endcase
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          st_reg <= fpsr_pkg::FPSR_TMR_IDLE;
          tmr_reg <= '0;
          fs_reg <= 1'b0;
        end else begin
          st_reg <= st_next;
          tmr_reg <= tmr_next;
          fs_reg <= fs_next;
        end
      end

      assign float_start[gi] = fs_reg;
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [15:0] rd_reg, rd_next;

  always_comb begin
    rd_next = rd_reg;
    if (reg_rd) begin
      rd_next = '0;
      unique case (1'b1)
        hit(reg_addr, `FPSR_ADDR_STATUS): begin
          // Reserved bits 7 and 4:0 never set, so ones written clear them
          rd_next[`FPSR_CNT_MSB:`FPSR_CNT_LSB] = cnt_reg;
          rd_next[`FPSR_FLAG_A_BIT] = flag_a_reg;
          rd_next[`FPSR_FLAG_B_BIT] = flag_b_reg;
        end
        hit(reg_addr, `FPSR_ADDR_MASK): rd_next = mask_reg;
        hit(reg_addr, `FPSR_ADDR_PULSE): rd_next = pulse_reg;
        hit(reg_addr, `FPSR_ADDR_FLOAT_A): rd_next = flt_a_reg;
        hit(reg_addr, `FPSR_ADDR_FLOAT_B): rd_next = flt_b_reg;
        default: rd_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign reg_rdata = rd_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Saturating run of slot A enable, so a legal mid-count abort passes
  localparam int PRECON_ONE_EDGES = `FPSR_PRECON_UNIT_CYC + 2;
  logic [7:0] en_hold_reg, en_hold_next;

  always_comb begin
    en_hold_next = !g_slot[0].en ? 8'h00 : en_hold_reg + 8'(en_hold_reg != 8'hff);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_hold_reg <= 8'h00;
    end else begin
      en_hold_reg <= en_hold_next;
    end
  end

  fire_a_mask_a: assert property (slot_a_pulse_req |=>
    slot_a_led_fire == !$past(skip_a[pulse_index]))
    else $error("Slot A fire disagrees with mask");
  fire_b_mask_a: assert property (slot_b_pulse_req && pulse_index == 2'h0 |=>
    slot_b_led_fire == !$past(pulse_reg[`FPSR_PULSE_B_LSB]))
    else $error("Slot B first pulse mask wrong");
  fifo_clear_a: assert property (clr_fifo |=> cnt_reg == '0 && fifo_clear)
    else $error("FIFO count not cleared");
  count_push_a: assert property (!clr_fifo && fifo_word_push && !fifo_byte_pop &&
    cnt_reg < 8'h10 |=> cnt_reg == $past(cnt_reg) + CNT_W'(2))
    else $error("Push did not add two bytes");
  flag_a_set_a: assert property (slot_a_sample_evt |=> flag_a_reg)
    else $error("Slot A flag missed event");
  flag_b_clr_a: assert property (wr_status && reg_wdata[`FPSR_FLAG_B_BIT] &&
    !slot_b_sample_evt |=> !flag_b_reg)
    else $error("Slot B flag not cleared");
  flag_keep_a: assert property (flag_a_reg && wr_status &&
    !reg_wdata[`FPSR_FLAG_A_BIT] |=> flag_a_reg)
    else $error("Writing zero cleared slot A flag");
  irq_fifo_a: assert property (fifo_over && !mask_reg[`FPSR_FIFO_MASK_BIT] |=> irq)
    else $error("FIFO threshold interrupt missing");
  irq_cause_a: assert property (irq |-> $past(
    flag_a_reg && !mask_reg[`FPSR_FLAG_A_BIT] || flag_b_reg && !mask_reg[`FPSR_FLAG_B_BIT] ||
    fifo_over && !mask_reg[`FPSR_FIFO_MASK_BIT]))
    else $error("Interrupt without unmasked cause");
  float_off_a: assert property (!g_slot[0].en && !$past(g_slot[0].en) |->
    !float_start[0])
    else $error("Float start while disabled");
  precon_zero_a: assert property (slot_start[1] && g_slot[1].en &&
    g_slot[1].precon == 5'h00 && g_slot[1].st_reg == fpsr_pkg::FPSR_TMR_IDLE ##1
    g_slot[1].en |=> float_start[1])
    else $error("Slot B zero precondition timing wrong");
  precon_len_a: assert property (slot_start[0] && g_slot[0].en &&
    g_slot[0].precon == 5'h01 && g_slot[0].st_reg == fpsr_pkg::FPSR_TMR_IDLE |->
    ##PRECON_ONE_EDGES (float_start[0] || en_hold_reg < 8'(PRECON_ONE_EDGES)))
    else $error("Slot A precondition delay wrong");

  fire_skip_c: cover property (slot_a_pulse_req && skip_a[pulse_index]);
  flag_race_c: cover property (slot_a_sample_evt && wr_status && reg_wdata[`FPSR_FLAG_A_BIT]);
  float_run_c: cover property (float_start[0]);
  irq_fifo_c: cover property (irq && fifo_over);

endmodule
`default_nettype wire

// ### test/fpsr_host.sv
// Host model that drives the register port of the block
`timescale 1ns/10ps
`default_nettype none
`include "fpsr_defs.svh"
module fpsr_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Fields held until the taking edge; data inverted after release
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #2;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #2;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic pmask(input logic [3:0] b, input logic [3:0] a);
    wr(`FPSR_ADDR_PULSE, {b, a, 8'h10});
  endtask
  // Only codes 0 and 3 are ever written to the enable field
  task automatic flt(input logic [7:0] a, input logic on, input logic [4:0] p);
    wr(a, {1'b0, (on ? `FPSR_FLT_EN_ON : 2'h0), p, 8'h08});
  endtask
  task automatic clr_status(input logic f, input logic b, input logic a);
    wr(`FPSR_ADDR_STATUS, {f, 7'h00, 1'b1, b, a, 5'h1f});
  endtask
  task automatic mask(input logic f, input logic b, input logic a);
    wr(`FPSR_ADDR_MASK, {7'h00, f, 1'b1, b, a, 5'h1f});
  endtask
endmodule
`default_nettype wire

// ### test/tb_fpsr_regs.sv
// Self-checking bench for the float, pulse and status register block
`timescale 1ns/10ps
`default_nettype none
`include "fpsr_defs.svh"
module tb_fpsr_regs;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, a_fire, b_fire, fclr, irq;
  logic sa_evt = 1'b0, sb_evt = 1'b0, push = 1'b0, pop = 1'b0, a_req = 1'b0, b_req = 1'b0;
  logic [5:0] thr = 6'h00;
  logic [1:0] idx = 2'h0, sstart = 2'h0, fstart;
  logic [7:0] m;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  fpsr_host u_fpsr_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  fpsr_regs u_fpsr_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot_a_sample_evt(sa_evt),
    .slot_b_sample_evt(sb_evt), .fifo_word_push(push), .fifo_byte_pop(pop),
    .fifo_thresh_words(thr), .slot_a_pulse_req(a_req), .slot_b_pulse_req(b_req),
    .pulse_index(idx), .slot_a_led_fire(a_fire), .slot_b_led_fire(b_fire),
    .slot_start(sstart), .float_start(fstart), .fifo_clear(fclr), .irq(irq));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    u_fpsr_host.rd(a, rv);
    chk_word(rv, e);
  endtask
  task automatic fire(input int s, input logic [1:0] i, input logic e);
    @(posedge clk);
    #2;
    idx = i;
    a_req = (s == 0);
    b_req = (s == 1);
    @(posedge clk);
    #2;
    a_req = 1'b0;
    b_req = 1'b0;
    chk_bit((s == 0) ? a_fire : b_fire, e);
  endtask
  // Edges from start request to float start; a bounded wait, never a hang
  task automatic flt_run(input int s, input logic [15:0] e);
    logic [15:0] n;
    n = 16'h0000;
    @(posedge clk);
    #2;
    sstart[s] = 1'b1;
    while (n < 16'h02bc && fstart[s] !== 1'b1) begin
      @(posedge clk);
      #2;
      sstart = 2'h0;
      n++;
    end
    chk_word(n, e);
  endtask
  task automatic strobe(input int w, input int n);
    repeat (n) begin
      @(posedge clk);
      #2;
      {pop, push, sb_evt, sa_evt} = 4'h1 << w;
      @(posedge clk);
      #2;
      {pop, push, sb_evt, sa_evt} = 4'h0;
    end
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #2;
    chk_bit(irq, e);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    #2;
    rst = 1'b0;
    rdchk(`FPSR_ADDR_STATUS, 16'h0000);
    rdchk(`FPSR_ADDR_MASK, 16'h01ff);
    rdchk(`FPSR_ADDR_PULSE, 16'h0010);
    rdchk(`FPSR_ADDR_FLOAT_A, 16'h0808);
    rdchk(`FPSR_ADDR_FLOAT_B, 16'h0808);
    rdchk(8'h33, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      m = (k == 0) ? 8'h69 : 8'h96;
      u_fpsr_host.pmask(m[7:4], m[3:0]);
      rdchk(`FPSR_ADDR_PULSE, {m, 8'h10});
      for (int i = 0; i < 4; i++) begin
        fire(0, i[1:0], ~m[i]);
        fire(1, i[1:0], ~m[4+i]);
      end
    end
    u_fpsr_host.flt(`FPSR_ADDR_FLOAT_A, 1'b1, 5'h08);
    flt_run(0, 16'h0282);
    u_fpsr_host.flt(`FPSR_ADDR_FLOAT_A, 1'b1, 5'h00);
    flt_run(0, 16'h0002);
    u_fpsr_host.flt(`FPSR_ADDR_FLOAT_B, 1'b1, 5'h01);
    flt_run(1, 16'h0052);
    u_fpsr_host.flt(`FPSR_ADDR_FLOAT_B, 1'b1, 5'h00);
    flt_run(1, 16'h0002);
    u_fpsr_host.flt(`FPSR_ADDR_FLOAT_A, 1'b1, 5'h01);
    flt_run(0, 16'h0052);
    u_fpsr_host.flt(`FPSR_ADDR_FLOAT_A, 1'b0, 5'h01);
    flt_run(0, 16'h02bc);
    thr = 6'h03;
    u_fpsr_host.mask(1'b0, 1'b0, 1'b0);
    irq_is(1'b0);
    strobe(0, 1);
    rdchk(`FPSR_ADDR_STATUS, 16'h0020);
    irq_is(1'b1);
    u_fpsr_host.mask(1'b0, 1'b0, 1'b1);
    irq_is(1'b0);
    u_fpsr_host.clr_status(1'b0, 1'b0, 1'b0);
    strobe(1, 1);
    rdchk(`FPSR_ADDR_STATUS, 16'h0060);
    irq_is(1'b1);
    u_fpsr_host.clr_status(1'b0, 1'b0, 1'b1);
    rdchk(`FPSR_ADDR_STATUS, 16'h0040);
    u_fpsr_host.clr_status(1'b0, 1'b1, 1'b0);
    rdchk(`FPSR_ADDR_STATUS, 16'h0000);
    irq_is(1'b0);
    strobe(2, 3);
    strobe(3, 1);
    rdchk(`FPSR_ADDR_STATUS, 16'h0500);
    irq_is(1'b0);
    thr = 6'h02;
    irq_is(1'b1);
    u_fpsr_host.mask(1'b1, 1'b1, 1'b1);
    irq_is(1'b0);
    u_fpsr_host.clr_status(1'b1, 1'b0, 1'b0);
    chk_bit(fclr, 1'b1);
    rdchk(`FPSR_ADDR_STATUS, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
